// File: verilog/sdc_pkg.sv
/*
 * constants and carrier types for the sysref divider configuration block.
 * assumes a 40 MHz system clock and a 32-bit apb register bus.
 */
package sdc_pkg;

	// register indices; the byte address is four times the index
	localparam logic [9:0] SDC_IDX_DIV_CTRL = 10'h018;
	localparam logic [9:0] SDC_IDX_POWER_BIAS_SYNC = 10'h019;
	localparam logic [9:0] SDC_IDX_PULSE_CTRL = 10'h01A;
	localparam logic [9:0] SDC_IDX_GLOBAL_DELAY = 10'h01B;
	localparam logic [9:0] SDC_IDX_VCXO_MOD_SRC = 10'h01C;
	localparam logic [9:0] SDC_IDX_LOCK_SDO = 10'h01F;
	localparam logic [9:0] SDC_IDX_STATUS = 10'h021;
	localparam logic [9:0] SDC_IDX_SOFT_RESET = 10'h070;

	// values after reset
	localparam logic [7:0] SDC_RST_DIV_CTRL = 8'h00;
	localparam logic [7:0] SDC_RST_POWER_BIAS_SYNC = 8'h40;
	localparam logic [7:0] SDC_RST_OTHER = 8'h00;

	// field positions
	localparam int SDC_POS_TOP = 6;
	localparam int SDC_POS_SECOND = 4;
	localparam int SDC_POS_MID_HI = 3;
	localparam int SDC_POS_MID_LO = 2;
	localparam int SDC_POS_LOW = 0;
	localparam int SDC_POS_POWER_DOWN = 7;
	localparam int SDC_POS_SOFT_RESET = 7;

	// divider stage ratios
	localparam int SDC_STAGES = 5;
	localparam logic [4:0] SDC_RATIO_BASE = 5'h02;
	localparam logic [4:0] SDC_RATIO_MID_SET = 5'h04;
	localparam logic [15:0] SDC_FIXED_RATIO = 16'h0002;

	// configuration handed to the rest of the sysref path
	typedef struct packed {
		logic power_down;
		logic bias_type;
		logic [5:0] sync;
		logic [7:0] pulse_count;
		logic [7:0] global_delay;
		logic [7:0] vcxo_out_mod_enable;
		logic sysref_input_source;
		logic sysref_gen_ctrl;
		logic sysref_out_ctrl;
		logic vcxo_lock_loss_mask;
		logic serial_out_active;
		logic vcxo_sysref_sel_hi;
		logic vcxo_sysref_sel_lo;
	} sdc_cfg_s;

endpackage

// File: verilog/sdc_stage.sv
/*
 * one serial stage of the sysref divider: passes every n-th input tick.
 * assumes ratio is at least two and that ticks come as one-cycle pulses.
 */
`timescale 1ns/10ps
module sdc_stage (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic tick_in,
	input wire logic [4:0] ratio,
	output logic tick_out
);
	import sdc_pkg::*;

	logic [4:0] cnt;
	logic [4:0] next_cnt;
	wire logic wrap;

	// >= keeps the count bounded when software lowers the ratio mid-period
	assign wrap = (cnt >= ratio - 5'h01);

	always_comb begin
		next_cnt = cnt;
		if (tick_in) begin
			next_cnt = wrap ? 5'h00 : cnt + 5'h01;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || clr) begin
			cnt <= 5'h00;
			tick_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_out <= tick_in && wrap;
		end
	end

endmodule

// File: verilog/sdc_top.sv
/*
 * sysref divider configuration: apb register file and the divider cascade.
 * assumes apb signals synchronous to sys_clk and a synchronous reset.
 */
// Notes on behaviour
// - total ratio is two times stage ratios
// - top field codes select 2, 4, 8, 16
// - single-bit middle stages select 2 or 4
// - lowest field codes select 2 through 5
`timescale 1ns/10ps
module sdc_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic sysref_div_out,
	output sdc_pkg::sdc_cfg_s cfg
);
	import sdc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] sysref_divider_ctrl;
	logic [7:0] sysref_power_bias_sync;
	logic [7:0] sysref_pulse_ctrl;
	logic [7:0] sysref_global_delay;
	logic [7:0] vcxo_out_mod_and_sysref_src;
	logic [7:0] lock_block_serial_out_ctrl;
	logic [15:0] ratio_status;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire logic [9:0] idx;
	wire logic aligned;
	wire logic access;
	wire logic wr_en;
	wire logic hit_div;
	wire logic hit_pbs;
	wire logic hit_pulse;
	wire logic hit_delay;
	wire logic hit_mod;
	wire logic hit_lock;
	wire logic hit_status;
	wire logic hit_rst;
	wire logic mapped;
	wire logic soft_reset;
	wire logic [7:0] wbyte;
	logic [31:0] next_prdata;

	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'h0);
	// one wait state: pready rises in the second access cycle
	assign access = psel && penable && !pready;
	assign wr_en = psel && penable && pready && pwrite && mapped && pstrb[0];
	assign wbyte = pwdata[7:0];
	assign hit_div = aligned && (idx == SDC_IDX_DIV_CTRL);
	assign hit_pbs = aligned && (idx == SDC_IDX_POWER_BIAS_SYNC);
	assign hit_pulse = aligned && (idx == SDC_IDX_PULSE_CTRL);
	assign hit_delay = aligned && (idx == SDC_IDX_GLOBAL_DELAY);
	assign hit_mod = aligned && (idx == SDC_IDX_VCXO_MOD_SRC);
	assign hit_lock = aligned && (idx == SDC_IDX_LOCK_SDO);
	assign hit_status = aligned && (idx == SDC_IDX_STATUS);
	assign hit_rst = aligned && (idx == SDC_IDX_SOFT_RESET);
	assign mapped = hit_div || hit_pbs || hit_pulse || hit_delay ||
		hit_mod || hit_lock || hit_status || hit_rst;
	// the soft reset bit never holds: it acts once and reads back as zero
	assign soft_reset = wr_en && hit_rst && wbyte[SDC_POS_SOFT_RESET];

	always_comb begin
		next_prdata = 32'h00000000;
		if (hit_div) begin
			next_prdata[7:0] = sysref_divider_ctrl;
		end else if (hit_pbs) begin
			next_prdata[7:0] = sysref_power_bias_sync;
		end else if (hit_pulse) begin
			next_prdata[7:0] = sysref_pulse_ctrl;
		end else if (hit_delay) begin
			next_prdata[7:0] = sysref_global_delay;
		end else if (hit_mod) begin
			next_prdata[7:0] = vcxo_out_mod_and_sysref_src;
		end else if (hit_lock) begin
			next_prdata[7:0] = lock_block_serial_out_ctrl;
		end else if (hit_status) begin
			next_prdata[16:0] = {sysref_div_out, ratio_status};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
			prdata <= (access && !pwrite) ? next_prdata : 32'h00000000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || soft_reset) begin
			sysref_divider_ctrl <= SDC_RST_DIV_CTRL;
			sysref_power_bias_sync <= SDC_RST_POWER_BIAS_SYNC;
			sysref_pulse_ctrl <= SDC_RST_OTHER;
			sysref_global_delay <= SDC_RST_OTHER;
			vcxo_out_mod_and_sysref_src <= SDC_RST_OTHER;
			lock_block_serial_out_ctrl <= SDC_RST_OTHER;
		end else if (wr_en) begin
			if (hit_div) begin
				sysref_divider_ctrl <= wbyte;
			end
			if (hit_pbs) begin
				sysref_power_bias_sync <= wbyte;
			end
			if (hit_pulse) begin
				sysref_pulse_ctrl <= wbyte;
			end
			if (hit_delay) begin
				sysref_global_delay <= wbyte;
			end
			if (hit_mod) begin
				vcxo_out_mod_and_sysref_src <= wbyte;
			end
			if (hit_lock) begin
				lock_block_serial_out_ctrl <= wbyte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stage ratio decode

	wire logic [1:0] sysref_div_select_top;
	wire logic [1:0] sysref_div_select_second;
	wire logic [1:0] sysref_div_select_low;
	wire logic [4:0] ratio [SDC_STAGES];
	wire logic power_down;
	wire logic [15:0] next_ratio_status;

	assign sysref_div_select_top = sysref_divider_ctrl[SDC_POS_TOP +: 2];
	assign sysref_div_select_second = sysref_divider_ctrl[SDC_POS_SECOND +: 2];
	assign sysref_div_select_low = sysref_divider_ctrl[SDC_POS_LOW +: 2];
	assign ratio[0] = SDC_RATIO_BASE << sysref_div_select_top;
	assign ratio[1] = SDC_RATIO_BASE + {3'h0, sysref_div_select_second};
	assign ratio[2] = sysref_divider_ctrl[SDC_POS_MID_HI] ?
		SDC_RATIO_MID_SET : SDC_RATIO_BASE;
	assign ratio[3] = sysref_divider_ctrl[SDC_POS_MID_LO] ?
		SDC_RATIO_MID_SET : SDC_RATIO_BASE;
	assign ratio[4] = SDC_RATIO_BASE + {3'h0, sysref_div_select_low};
	assign power_down = sysref_power_bias_sync[SDC_POS_POWER_DOWN];
	// largest product is 12800, so sixteen bits never overflow
	assign next_ratio_status = SDC_FIXED_RATIO * {11'h000, ratio[0]} *
		{11'h000, ratio[1]} * {11'h000, ratio[2]} *
		{11'h000, ratio[3]} * {11'h000, ratio[4]};

	////////////////////////////////////////////////////////////////////////
	// divider cascade; the fixed divide-by-two is the output toggle

	wire logic [SDC_STAGES:0] tick;

	assign tick[0] = 1'b1;

	genvar g;
	generate
		for (g = 0; g < SDC_STAGES; g = g + 1) begin : g_stage
			sdc_stage u_stage (
				.sys_clk(sys_clk),
				.rst(rst),
				.clr(power_down),
				.tick_in(tick[g]),
				.ratio(ratio[g]),
				.tick_out(tick[g+1])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sysref_div_out <= 1'b0;
			ratio_status <= 16'h0000;
		end else begin
			ratio_status <= next_ratio_status;
			if (power_down) begin
				sysref_div_out <= 1'b0;
			end else if (tick[SDC_STAGES]) begin
				sysref_div_out <= !sysref_div_out;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration outputs

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cfg <= '0;
		end else begin
			cfg.power_down <= sysref_power_bias_sync[7];
			cfg.bias_type <= sysref_power_bias_sync[6];
			cfg.sync <= sysref_power_bias_sync[5:0];
			cfg.pulse_count <= sysref_pulse_ctrl;
			cfg.global_delay <= sysref_global_delay;
			cfg.vcxo_out_mod_enable <= {vcxo_out_mod_and_sysref_src[7:4],
				lock_block_serial_out_ctrl[3:0]};
			cfg.sysref_input_source <= vcxo_out_mod_and_sysref_src[2];
			cfg.sysref_gen_ctrl <= vcxo_out_mod_and_sysref_src[1];
			cfg.sysref_out_ctrl <= vcxo_out_mod_and_sysref_src[0];
			cfg.vcxo_lock_loss_mask <= lock_block_serial_out_ctrl[7];
			cfg.serial_out_active <= lock_block_serial_out_ctrl[6];
			cfg.vcxo_sysref_sel_hi <= lock_block_serial_out_ctrl[5];
			cfg.vcxo_sysref_sel_lo <= lock_block_serial_out_ctrl[4];
		end
	end

endmodule

// File: verif/sdc_chk.sv
/* assertions on the ports of the sysref divider block.
 * assumes it is bound to sdc_top and sees its apb and output ports. */
`timescale 1ns/10ps
module sdc_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sysref_div_out
);
////////////////////////////////////////////////////////////////
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
wire st_rd = pready && !pwrite && paddr == 12'h084;
wait_state_a: assert property (psel && penable && !pready |=> pready)
	else $error("no answer after one wait state");
ready_pulse_a: assert property (pready |=> !pready)
	else $error("pready held too long");
idle_quiet_a: assert property (!psel |=> !pready)
	else $error("pready without a request");
quiet_bus_a: assert property (!pready |-> prdata == 32'h0)
	else $error("read data outside a transfer");
err_silent_a: assert property (pslverr |-> pready && prdata == 32'h0)
	else $error("error answer carries data");
ratio_even_a: assert property (st_rd |-> !prdata[0])
	else $error("total ratio not even");
ratio_span_a: assert property (st_rd |-> prdata[15:0] >= 16'h0040 &&
	prdata[15:0] <= 16'h6400) else $error("total ratio out of range");
// reset is the antecedent here, so the default disable must not apply
reset_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
	rst |=> !pready && !sysref_div_out)
	else $error("outputs active in reset");
endmodule

// File: verif/tb_top.sv
/* self-checking bench for sdc_top over apb.
 * assumes one wait state per transfer and the sdc_pkg register map. */
`timescale 1ns/10ps
module tb_top;
import sdc_pkg::*;
logic sys_clk = 1'b0;
logic rst = 1'b1;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0;
logic [3:0] pstrb = 4'hF;
logic [31:0] prdata, rd;
logic pready, pslverr, sysref_div_out, er, last;
sdc_cfg_s cfg;
int fails = 0;
int checks = 0;
int n;
logic [7:0] tv [12] = '{8'h40, 8'h80, 8'hC0, 8'h10, 8'h20, 8'h30, 8'h08,
	8'h04, 8'h01, 8'h02, 8'h03, 8'hFF};
logic [7:0] pv [3] = '{8'h00, 8'h41, 8'h0C};
always #12.5 sys_clk = ~sys_clk;
always @(posedge sys_clk) last <= sysref_div_out;
sdc_top sdc_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sysref_div_out(sysref_div_out), .cfg(cfg));
////////////////////////////////////////////////////////////////
task final_report;
	$display("checks %0d fails %0d", checks, fails);
	if (fails == 0 && checks > 0)
		$display("Result: passed");
	else
		$display("Result: failed");
	$finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
	checks++;
	if (got !== exp) begin
		fails++;
		$display("unexpected at %0t: %s got %h", $time, m, got);
	end
endtask
// one full apb transfer; the answer is taken at the pready edge only
task acc(input logic w, input logic [11:0] a, input logic [31:0] d,
	input logic [3:0] s);
	int c;
	@(posedge sys_clk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	pstrb <= s;
	@(posedge sys_clk);
	penable <= 1'b1;
	c = 0;
	do begin
		@(posedge sys_clk);
		c++;
	end while (pready !== 1'b1 && c < 20);
	if (c >= 20) begin
		fails++;
		final_report();
	end
	rd = prdata;
	er = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
endtask
// cycles until the next rising edge of the divided output
task rise(output int c);
	c = 0;
	do begin
		@(posedge sys_clk);
		c++;
	end while (!(sysref_div_out === 1'b1 && last === 1'b0) && c < 9000);
	if (c >= 9000) begin
		fails++;
		final_report();
	end
endtask
function automatic logic [31:0] ratio(input logic [7:0] v);
	ratio = 32'h2 * (32'h2 << v[7:6]) * (v[5:4] + 32'h2) *
		(v[3] ? 32'h4 : 32'h2) * (v[2] ? 32'h4 : 32'h2) * (v[1:0] + 32'h2);
endfunction
////////////////////////////////////////////////////////////////
initial begin
	repeat (12) @(posedge sys_clk);
	rst <= 1'b0;
	acc(1'b0, 12'h060, 32'h0, 4'hF);
	chk(rd, {24'h0, SDC_RST_DIV_CTRL}, "div reset");
	acc(1'b0, 12'h064, 32'h0, 4'hF);
	chk(rd, {24'h0, SDC_RST_POWER_BIAS_SYNC}, "bias reset");
	chk({31'h0, cfg.bias_type}, 32'h1, "cfg bias reset");
	acc(1'b0, 12'h084, 32'h0, 4'hF);
	chk(rd & 32'h0000FFFF, ratio(8'h00), "ratio reset");
	$display("test reset values done");
	foreach (tv[i]) begin
		acc(1'b1, 12'h060, {24'h0, tv[i]}, 4'hF);
		acc(1'b0, 12'h060, 32'h0, 4'hF);
		chk(rd, {24'h0, tv[i]}, "div readback");
		acc(1'b0, 12'h084, 32'h0, 4'hF);
		chk(rd & 32'h0000FFFF, ratio(tv[i]), "ratio");
	end
	$display("test ratio table done");
	// the first two rises may still mix old and new counter phases
	for (int k = 0; k < 3; k++) begin
		acc(1'b1, 12'h060, {24'h0, pv[k]}, 4'hF);
		rise(n);
		rise(n);
		rise(n);
		chk(n, ratio(pv[k]), "output period");
	end
	$display("test output period done");
	acc(1'b1, 12'h064, 32'hC0, 4'hF);
	repeat (2) @(posedge sys_clk);
	n = 0;
	repeat (300) begin
		@(posedge sys_clk);
		n += sysref_div_out;
	end
	chk(n, 32'h0, "power down output");
	chk({31'h0, cfg.power_down}, 32'h1, "cfg power down");
	acc(1'b1, 12'h064, 32'h40, 4'hF);
	$display("test power down done");
	acc(1'b0, 12'h0FC, 32'h0, 4'hF);
	chk({31'h0, er}, 32'h1, "unmapped");
	acc(1'b1, 12'h061, 32'h5A, 4'hF);
	chk({31'h0, er}, 32'h1, "misaligned");
	acc(1'b0, 12'h060, 32'h0, 4'hF);
	chk(rd, {24'h0, pv[2]}, "misaligned ignored");
	acc(1'b1, 12'h068, 32'h5A, 4'hE);
	acc(1'b0, 12'h068, 32'h0, 4'hF);
	chk(rd, 32'h0, "strobe off");
	acc(1'b1, 12'h068, 32'h5A, 4'hF);
	// cfg follows the register one edge after the write lands
	repeat (2) @(posedge sys_clk);
	chk({24'h0, cfg.pulse_count}, 32'h5A, "cfg copy");
	acc(1'b1, 12'h1C0, 32'h80, 4'hF);
	acc(1'b0, 12'h060, 32'h0, 4'hF);
	chk(rd, {24'h0, SDC_RST_DIV_CTRL}, "soft reset");
	$display("test refusals and soft reset done");
	final_report();
end
endmodule
bind sdc_top sdc_chk sdc_chk_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sysref_div_out(sysref_div_out));
